// file: hw/pcc_regs.svh
// Constants of the configuration header front: offsets, bit positions,
// fixed field values. Included by the header front by bare name.
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// ----------------------------------------------------------------
// Configuration space offsets, as printed (byte addresses)
// ----------------------------------------------------------------
`define PCC_OFS_DEVICE_IDENTIFIER 8'h02
`define PCC_OFS_COMMAND 8'h04
`define PCC_OFS_STATUS 8'h06
`define PCC_OFS_REVISION 8'h08

// ----------------------------------------------------------------
// Command register bit positions
// ----------------------------------------------------------------
`define PCC_CMD_IO 0
`define PCC_CMD_MEM 1
`define PCC_CMD_BM 2
`define PCC_CMD_PRE 6
`define PCC_CMD_SEE 8
`define PCC_CMD_RW_MASK 16'h0147

// ----------------------------------------------------------------
// Status register bit positions and fixed fields
// ----------------------------------------------------------------
`define PCC_STS_DPE 15
`define PCC_STS_SSE 14
`define PCC_STS_RMA 13
`define PCC_STS_RTA 12
`define PCC_STS_STA 11
`define PCC_STS_DEVSEL_HI 10
`define PCC_STS_DEVSEL_LO 9
`define PCC_STS_MDPE 8
`define PCC_STS_FBC 7
`define PCC_STS_CAP 4
`define PCC_DEVSEL_MEDIUM 2'h1
`define PCC_STS_FIXED 16'h0290
`define PCC_STS_W1C_MASK 16'hF100

// ----------------------------------------------------------------
// Word layout: the upper half of a dword starts at this bit
// ----------------------------------------------------------------
`define PCC_HALF_LANE 16
`define PCC_ZERO_WORD 32'h0000_0000
`define PCC_ZERO_HALF 16'h0000

`endif

// file: hw/pcc_pkg.sv
// Types shared by the configuration header front and its parity checker.
// Assumes the constants header supplies every number.
package pcc_pkg;

  // ----------------------------------------------------------------
  // Kind of bus phase being parity checked
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCC_CHK_NONE,
    PCC_CHK_ADDR,
    PCC_CHK_TWR,
    PCC_CHK_MRD
  } pcc_chk_t;

  // ----------------------------------------------------------------
  // Target claim sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCC_TGT_IDLE,
    PCC_TGT_DECODE,
    PCC_TGT_CLAIM
  } pcc_tgt_t;

  // Parity checker state
  typedef struct packed {
    pcc_chk_t kind_p;
    logic odd_p;
    logic err;
    pcc_chk_t err_kind;
  } pcc_par_t;

  // Header front state
  typedef struct packed {
    pcc_tgt_t tgt;
    logic frame_q;
    logic io_en;
    logic mem_en;
    logic bm_en;
    logic pre;
    logic see;
    logic f_dpe;
    logic f_sse;
    logic f_rma;
    logic f_rta;
    logic f_mdpe;
    logic [31:0] rdata;
    logic rvalid;
    logic devsel_n;
    logic devsel_oe;
    logic perr_n;
    logic perr_oe;
    logic serr_n;
    logic serr_oe;
    logic rom_en;
    logic bus_req;
  } pcc_state_t;

endpackage

// file: hw/pcc_parity_chk.sv
// Even parity checker over AD, C/BE and PAR.
// Assumes PAR arrives one clock after the AD and C/BE it covers.
`timescale 1ns/1ps
module pcc_parity_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus sampling
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  input wire logic par_i,
  input wire pcc_pkg::pcc_chk_t kind_i,
  // Result, one cycle pulse
  output logic err_o,
  output pcc_pkg::pcc_chk_t err_kind_o
);
  import pcc_pkg::*;

  pcc_par_t q;
  pcc_par_t d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Parity of the phase is held one clock to meet its PAR
  always_comb begin
    d = q;
    d.odd_p = ^{ad_i, cbe_i};
    d.kind_p = kind_i;
    d.err = (q.kind_p != PCC_CHK_NONE) && (q.odd_p != par_i);
    d.err_kind = q.kind_p;
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{kind_p: PCC_CHK_NONE, err_kind: PCC_CHK_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign err_o = q.err;
  assign err_kind_o = q.err_kind;
endmodule

// file: hw/pcc_cfg_front.sv
// Configuration header front: device identifier, command, status and
// revision identifier, with target claim and parity error reporting.
// Assumes all inputs synchronous to clk_i, and outside decoders that
// flag base-address hits during the address phase.
//
// Contract
// - Unused command enables read zero, writes ignored
// - SERR and its flag need both enables
// - Parity response enable gates PERR pin
// - Master only while bus master enable set
// - Memory and ROM accesses need memory enable
// - I/O accesses ignored while I/O enable clear
// - Hardware reset clears command and flags
// - Detected parity flag ignores response enable
// - Check parity: address, target writes, master reads
// - Target PERR during master write sets flag
// - Flags clear by writing one only
// - Master abort sets received master abort
// - Target abort sets received target abort
// - Signaled target abort reads zero always
// - Medium decode, DEVSEL two clocks after FRAME
// - Master data parity flag needs response enable
// - Fast back-to-back capable reads one
// - Capability list bit reads one
// - Reserved command and status bits read zero
// - Read-only identifiers at offsets 02h, 08h
`timescale 1ns/1ps
`include "pcc_regs.svh"
module pcc_cfg_front #(
  parameter logic [15:0] DEVICE_IDENTIFIER = 16'hC0DE, // Arbitrary value
  parameter logic [3:0] REV_FIXED = 4'h5, // Arbitrary value
  parameter logic [3:0] REV_SILICON = 4'h0 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Configuration access
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Bus sampling
  input wire logic frame_n_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  input wire logic par_i,
  input wire logic perr_n_i,
  // Decode and transfer qualifiers
  input wire logic io_hit_i,
  input wire logic mem_hit_i,
  input wire logic rom_hit_i,
  input wire logic expansion_rom_enable_i,
  input wire logic tgt_done_i,
  input wire logic tgt_wr_xfer_i,
  input wire logic mst_rd_xfer_i,
  input wire logic mst_wr_xfer_i,
  input wire logic mst_master_abort_i,
  input wire logic mst_target_abort_i,
  input wire logic mst_req_i,
  // Pin drivers
  output logic devsel_n_o,
  output logic devsel_oe_o,
  output logic perr_n_o,
  output logic perr_oe_o,
  output logic serr_n_o,
  output logic serr_oe_o,
  // Enables to the rest of the controller
  output logic io_space_enable_o,
  output logic memory_space_enable_o,
  output logic bus_master_enable_o,
  output logic parity_response_enable_o,
  output logic system_error_enable_o,
  output logic rom_decode_enable_o,
  output logic bus_req_o
);
  import pcc_pkg::*;

  localparam pcc_state_t ST_RST = '{tgt: PCC_TGT_IDLE, frame_q: 1'b1,
    devsel_n: 1'b1, perr_n: 1'b1, serr_n: 1'b1, default: '0};

  pcc_state_t q;
  pcc_state_t d;
  pcc_chk_t chk_kind;
  pcc_chk_t par_kind;
  logic par_err;
  logic addr_phase;
  logic any_hit;
  logic wr_word;
  logic sts_clr;
  logic mst_wr_perr;
  logic addr_perr;
  logic data_perr;
  logic dpe_set;
  logic sse_set;
  logic mdpe_set;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Dword index of a configuration byte address
  function automatic logic [5:0] word_idx(input logic [7:0] a);
    word_idx = a[7:2];
  endfunction

  // Hardware set beats a same-cycle clear, so no event is lost
  function automatic logic w1c(input logic cur, input logic set,
                               input logic clr);
    w1c = set || (cur && !clr);
  endfunction

  // Read image of one dword; unmapped words and fields outside this
  // block read as zero
  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input pcc_state_t s);
    logic [15:0] cmd;
    logic [15:0] sts;
    logic [31:0] w;
    cmd = `PCC_ZERO_HALF;
    cmd[`PCC_CMD_IO] = s.io_en;
    cmd[`PCC_CMD_MEM] = s.mem_en;
    cmd[`PCC_CMD_BM] = s.bm_en;
    cmd[`PCC_CMD_PRE] = s.pre;
    cmd[`PCC_CMD_SEE] = s.see;
    sts = `PCC_STS_FIXED;
    sts[`PCC_STS_DPE] = s.f_dpe;
    sts[`PCC_STS_SSE] = s.f_sse;
    sts[`PCC_STS_RMA] = s.f_rma;
    sts[`PCC_STS_RTA] = s.f_rta;
    sts[`PCC_STS_MDPE] = s.f_mdpe;
    w = `PCC_ZERO_WORD;
    if (word_idx(a) == word_idx(`PCC_OFS_DEVICE_IDENTIFIER)) begin
      w = {DEVICE_IDENTIFIER, `PCC_ZERO_HALF};
    end else if (word_idx(a) == word_idx(`PCC_OFS_COMMAND)) begin
      w = {sts, cmd};
    end else if (word_idx(a) == word_idx(`PCC_OFS_REVISION)) begin
      w[7:0] = {REV_FIXED, REV_SILICON};
    end
    read_word = w;
  endfunction

  // ----------------------------------------------------------------
  // Parity checking
  // ----------------------------------------------------------------
  // Address phases are checked whether or not they hit this device
  always_comb begin
    if (addr_phase) begin
      chk_kind = PCC_CHK_ADDR;
    end else if (tgt_wr_xfer_i) begin
      chk_kind = PCC_CHK_TWR;
    end else if (mst_rd_xfer_i) begin
      chk_kind = PCC_CHK_MRD;
    end else begin
      chk_kind = PCC_CHK_NONE;
    end
  end

  pcc_parity_chk u_par (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ad_i(ad_i),
    .cbe_i(cbe_i),
    .par_i(par_i),
    .kind_i(chk_kind),
    .err_o(par_err),
    .err_kind_o(par_kind)
  );

  // ----------------------------------------------------------------
  // Event and decode terms
  // ----------------------------------------------------------------
  assign addr_phase = q.frame_q && !frame_n_i;
  assign any_hit = (io_hit_i && q.io_en)
    || (mem_hit_i && q.mem_en)
    || (rom_hit_i && expansion_rom_enable_i && q.mem_en);
  assign mst_wr_perr = mst_wr_xfer_i && !perr_n_i;
  assign addr_perr = par_err && (par_kind == PCC_CHK_ADDR);
  assign data_perr = par_err && (par_kind != PCC_CHK_ADDR);
  assign dpe_set = par_err || mst_wr_perr;
  assign sse_set = addr_perr && q.see && q.pre;
  assign mdpe_set = q.pre && (mst_wr_perr ||
    (par_err && (par_kind == PCC_CHK_MRD)));
  assign wr_word = cfg_wr_i
    && (word_idx(cfg_addr_i) == word_idx(`PCC_OFS_COMMAND));
  assign sts_clr = wr_word && cfg_be_i[3];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.frame_q = frame_n_i;
    // Command: only the implemented enables take write data; a zero
    // write to byte lanes 0 and 1 drops every enable at once
    if (wr_word && cfg_be_i[0]) begin
      d.io_en = cfg_wdata_i[`PCC_CMD_IO];
      d.mem_en = cfg_wdata_i[`PCC_CMD_MEM];
      d.bm_en = cfg_wdata_i[`PCC_CMD_BM];
      d.pre = cfg_wdata_i[`PCC_CMD_PRE];
    end
    if (wr_word && cfg_be_i[1]) begin
      d.see = cfg_wdata_i[`PCC_CMD_SEE];
    end
    // Status flags: write one clears, write zero keeps
    d.f_dpe = w1c(q.f_dpe, dpe_set, sts_clr &&
      cfg_wdata_i[`PCC_HALF_LANE + `PCC_STS_DPE]);
    d.f_sse = w1c(q.f_sse, sse_set, sts_clr &&
      cfg_wdata_i[`PCC_HALF_LANE + `PCC_STS_SSE]);
    d.f_rma = w1c(q.f_rma, mst_master_abort_i, sts_clr &&
      cfg_wdata_i[`PCC_HALF_LANE + `PCC_STS_RMA]);
    d.f_rta = w1c(q.f_rta, mst_target_abort_i, sts_clr &&
      cfg_wdata_i[`PCC_HALF_LANE + `PCC_STS_RTA]);
    d.f_mdpe = w1c(q.f_mdpe, mdpe_set, sts_clr &&
      cfg_wdata_i[`PCC_HALF_LANE + `PCC_STS_MDPE]);
    // Read port answers one clock after the request
    d.rvalid = cfg_rd_i;
    d.rdata = cfg_rd_i ? read_word(cfg_addr_i, q) : `PCC_ZERO_WORD;
    // Target claim: decode clock, then DEVSEL; a new address is taken
    // only when idle, so fast back-to-back to us after another target
    // works
    case (q.tgt)
      PCC_TGT_IDLE: begin
        if (addr_phase && any_hit) begin
          d.tgt = PCC_TGT_DECODE;
        end
      end
      PCC_TGT_DECODE: begin
        d.tgt = PCC_TGT_CLAIM;
      end
      PCC_TGT_CLAIM: begin
        if (tgt_done_i) begin
          d.tgt = PCC_TGT_IDLE;
        end
      end
      default: begin
        d.tgt = PCC_TGT_IDLE;
      end
    endcase
    // DEVSEL is driven high for one clock before it is released
    d.devsel_n = (d.tgt != PCC_TGT_CLAIM);
    d.devsel_oe = (d.tgt == PCC_TGT_CLAIM) || (q.tgt == PCC_TGT_CLAIM);
    // PERR low for one clock per error, then one clock driven high
    d.perr_n = !(data_perr && q.pre);
    d.perr_oe = (data_perr && q.pre) || !q.perr_n;
    // SERR is open drain: enable only while pulling low
    d.serr_n = !sse_set;
    d.serr_oe = sse_set;
    // Enables to the rest of the controller
    d.rom_en = expansion_rom_enable_i && d.mem_en;
    d.bus_req = mst_req_i && q.bm_en;
  end

  // State register; only the hardware reset clears it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign cfg_rdata_o = q.rdata;
  assign cfg_rvalid_o = q.rvalid;
  assign devsel_n_o = q.devsel_n;
  assign devsel_oe_o = q.devsel_oe;
  assign perr_n_o = q.perr_n;
  assign perr_oe_o = q.perr_oe;
  assign serr_n_o = q.serr_n;
  assign serr_oe_o = q.serr_oe;
  assign io_space_enable_o = q.io_en;
  assign memory_space_enable_o = q.mem_en;
  assign bus_master_enable_o = q.bm_en;
  assign parity_response_enable_o = q.pre;
  assign system_error_enable_o = q.see;
  assign rom_decode_enable_o = q.rom_en;
  assign bus_req_o = q.bus_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_addr_hit;
    (q.tgt == PCC_TGT_IDLE) && addr_phase && any_hit;
  endsequence

  sequence s_claim_rise;
    !devsel_oe_o ##1 (devsel_oe_o && !devsel_n_o);
  endsequence

  a_devsel_medium: assert property (
    s_addr_hit |=> s_claim_rise)
    else $error("DEVSEL not asserted two clocks after FRAME");

  a_io_gated: assert property (
    (q.tgt == PCC_TGT_IDLE) && addr_phase && io_hit_i && !q.io_en
      && !mem_hit_i && !rom_hit_i |-> ##2 !devsel_oe_o)
    else $error("I/O access claimed while I/O disabled");

  a_mem_gated: assert property (
    (q.tgt == PCC_TGT_IDLE) && addr_phase && !q.mem_en && !io_hit_i
      |-> ##2 !devsel_oe_o)
    else $error("Memory access claimed while memory disabled");

  a_serr_both: assert property (
    serr_oe_o |-> $past(q.see) && $past(q.pre) && q.f_sse)
    else $error("SERR driven without both enables");

  a_perr_quiet: assert property (
    data_perr && !q.pre |=> perr_n_o)
    else $error("PERR pulled low with response disabled");

  a_dpe_sets: assert property (
    dpe_set |=> q.f_dpe)
    else $error("Detected parity flag missed an error");

  a_w1c_hold: assert property (
    q.f_rma && wr_word && !cfg_wdata_i[`PCC_HALF_LANE + `PCC_STS_RMA]
      |=> q.f_rma)
    else $error("Status flag lost on a zero write");

  a_mdpe_cause: assert property (
    $rose(q.f_mdpe) |-> $past(q.pre) && $past(mdpe_set))
    else $error("Master data parity flag set without cause");

  a_mabort_sets: assert property (
    mst_master_abort_i |=> q.f_rma)
    else $error("Master abort not recorded");

  a_cmd_fixed: assert property (
    cfg_rvalid_o && (word_idx($past(cfg_addr_i))
      == word_idx(`PCC_OFS_COMMAND))
      |-> (cfg_rdata_o[15:0] & ~`PCC_CMD_RW_MASK) == `PCC_ZERO_HALF)
    else $error("Fixed command bits read nonzero");

  a_sts_fixed: assert property (
    cfg_rvalid_o && (word_idx($past(cfg_addr_i))
      == word_idx(`PCC_OFS_COMMAND)) |-> (cfg_rdata_o[31:16]
      & ~`PCC_STS_W1C_MASK) == `PCC_STS_FIXED)
    else $error("Fixed status bits read wrong");

  a_bm_gate: assert property (
    bus_req_o |-> $past(q.bm_en))
    else $error("Bus request without bus master enable");
endmodule

// file: tb/pcc_host_model.sv
// Host bus model: drives FRAME, AD, C/BE, PAR and a target's PERR.
// Assumes its tasks are called at the falling edge of the PCI clock.
`timescale 1ns/1ps
module pcc_host_model (
  // Bus lines toward the device
  output logic frame_n_o,
  output logic [31:0] ad_o,
  output logic [3:0] cbe_o,
  output logic par_o,
  output logic perr_n_o
);
  // ----------------------------------------------------------------
  // Phase memory
  // ----------------------------------------------------------------
  logic [31:0] ad_last;
  logic [3:0] cbe_last;

  // Idle bus at time zero
  initial begin
    frame_n_o = 1'b1;
    ad_o = 32'h0000_0000;
    cbe_o = 4'h0;
    par_o = 1'b0;
    perr_n_o = 1'b1;
  end

  // Put one phase on AD and C/BE; FRAME falls only for an address
  task automatic drive(input logic [31:0] a, input logic [3:0] c,
                       input logic addr);
    ad_last = a;
    cbe_last = c;
    ad_o = a;
    cbe_o = c;
    frame_n_o = !addr;
  endtask

  // PAR trails its phase by one clock; turned-round AD shows inverse
  task automatic parity(input logic bad);
    par_o = ^{ad_last, cbe_last} ^ bad;
    ad_o = ~ad_last;
    cbe_o = ~cbe_last;
    frame_n_o = 1'b1;
  endtask

  // Released lines keep moving, so a stale value never looks valid
  task automatic idle();
    par_o = ~par_o;
    ad_o = ~ad_o;
  endtask

  // Target reports a data parity error; pulled up when released
  task automatic target_perr(input logic active);
    perr_n_o = !active;
  endtask
endmodule

// file: tb/tb_top.sv
// Bench for the configuration header front: register table, claim
// timing, parity reporting and event flags.
// Assumes the host bus model beside it and a 250 MHz clock.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [15:0] DEV_ID = 16'hB71E; // Arbitrary value
  localparam logic [3:0] REV_HI = 4'h6; // Arbitrary value
  localparam logic [3:0] REV_LO = 4'h9; // Arbitrary value
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] exp;
  } pcc_row_t;
  pcc_row_t rows [9];
  logic clk_i, nrst_i, cfg_rd_i, cfg_wr_i, cfg_rvalid_o;
  logic [7:0] cfg_addr_i;
  logic [3:0] cfg_be_i, cbe_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, ad_i;
  logic frame_n_i, par_i, perr_n_i, io_hit_i, mem_hit_i, rom_hit_i;
  logic expansion_rom_enable_i, tgt_done_i, tgt_wr_xfer_i;
  logic mst_rd_xfer_i, mst_wr_xfer_i, mst_master_abort_i;
  logic mst_target_abort_i, mst_req_i, devsel_n_o, devsel_oe_o;
  logic perr_n_o, perr_oe_o, serr_n_o, serr_oe_o, io_space_enable_o;
  logic memory_space_enable_o, bus_master_enable_o;
  logic parity_response_enable_o, system_error_enable_o;
  logic rom_decode_enable_o, bus_req_o;
  int bad_count = 0;
  int compares = 0;

  // ----------------------------------------------------------------
  // Device and host model
  // ----------------------------------------------------------------
  pcc_cfg_front #(.DEVICE_IDENTIFIER(DEV_ID), .REV_FIXED(REV_HI),
    .REV_SILICON(REV_LO)) u_dut (.clk_i, .nrst_i, .cfg_rd_i, .cfg_wr_i,
    .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o,
    .frame_n_i, .ad_i, .cbe_i, .par_i, .perr_n_i, .io_hit_i, .mem_hit_i,
    .rom_hit_i, .expansion_rom_enable_i, .tgt_done_i, .tgt_wr_xfer_i,
    .mst_rd_xfer_i, .mst_wr_xfer_i, .mst_master_abort_i,
    .mst_target_abort_i, .mst_req_i, .devsel_n_o, .devsel_oe_o,
    .perr_n_o, .perr_oe_o, .serr_n_o, .serr_oe_o, .io_space_enable_o,
    .memory_space_enable_o, .bus_master_enable_o,
    .parity_response_enable_o, .system_error_enable_o,
    .rom_decode_enable_o, .bus_req_o);
  pcc_host_model u_host (.frame_n_o(frame_n_i), .ad_o(ad_i),
    .cbe_o(cbe_i), .par_o(par_i), .perr_n_o(perr_n_i));

  // Clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got,
                            input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s: %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s: %b not %b", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One-cycle write strobe; the effect shows the cycle after
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] d);
    @(negedge clk_i);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_be_i = be;
    cfg_wdata_i = d;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
  endtask

  // Answer stands one cycle only, so it is looked at right then
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk_i);
    cfg_rd_i = 1'b1;
    cfg_addr_i = a;
    @(negedge clk_i);
    cfg_rd_i = 1'b0;
    check_bit(cfg_rvalid_o, 1'b1, "read answer");
    check_word(cfg_rdata_o, exp, "read data");
  endtask

  // Command half only; byte lane 3 left off so flags are untouched
  task automatic set_cmd(input logic [15:0] v);
    cfg_write(8'h04, 4'h3, {16'h0000, v});
  endtask

  // Clear every flag, then see the fixed status fields alone
  task automatic clr(input logic [15:0] cmd);
    cfg_write(8'h04, 4'h8, 32'hFFFF_FFFF);
    cfg_read(8'h04, {16'h0290, cmd});
  endtask

  // Address phase with one decoder hit; DEVSEL two clocks on, if any
  task automatic claim(input logic io, input logic mem, input logic rom,
                       input logic exp);
    @(negedge clk_i);
    {io_hit_i, mem_hit_i, rom_hit_i} = {io, mem, rom};
    u_host.drive(32'h1234_5678, 4'h6, 1'b1);
    @(negedge clk_i);
    {io_hit_i, mem_hit_i, rom_hit_i} = 3'b000;
    u_host.parity(1'b0);
    check_bit(devsel_oe_o, 1'b0, "devsel early");
    @(negedge clk_i);
    u_host.idle();
    check_bit(devsel_oe_o, exp, "devsel drive");
    check_bit(devsel_n_o, !exp, "devsel level");
    tgt_done_i = 1'b1;
    @(negedge clk_i);
    tgt_done_i = 1'b0;
    check_bit(devsel_n_o, 1'b1, "devsel high");
    check_bit(devsel_oe_o, exp, "devsel turn");
    @(negedge clk_i);
    check_bit(devsel_oe_o, 1'b0, "devsel off");
  endtask

  // Bad parity: kind 0 address, 1 target write, 2 master read
  task automatic bad_phase(input logic [1:0] kind, input logic serr,
                           input logic perr);
    @(negedge clk_i);
    tgt_wr_xfer_i = (kind == 2'd1);
    mst_rd_xfer_i = (kind == 2'd2);
    u_host.drive(32'h5A5A_0F0F, 4'h7, kind == 2'd0);
    @(negedge clk_i);
    {tgt_wr_xfer_i, mst_rd_xfer_i} = 2'b00;
    u_host.parity(1'b1);
    @(negedge clk_i);
    u_host.idle();
    check_bit(serr_oe_o | perr_oe_o, 1'b0, "pins early");
    @(negedge clk_i);
    check_bit(serr_oe_o, serr, "serr drive");
    check_bit(serr_n_o, !serr, "serr level");
    check_bit(perr_oe_o, perr, "perr drive");
    check_bit(perr_n_o, !perr, "perr level");
    @(negedge clk_i);
    check_bit(serr_oe_o, 1'b0, "serr one cycle");
    check_bit(perr_n_o, 1'b1, "perr high");
    check_bit(perr_oe_o, perr, "perr turn");
    @(negedge clk_i);
    check_bit(perr_oe_o, 1'b0, "perr off");
  endtask

  // Watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    {cfg_rd_i, cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = '0;
    {io_hit_i, mem_hit_i, rom_hit_i, expansion_rom_enable_i} = '0;
    {tgt_done_i, tgt_wr_xfer_i, mst_rd_xfer_i, mst_wr_xfer_i} = '0;
    {mst_master_abort_i, mst_target_abort_i, mst_req_i} = '0;
    rows[0] = '{1'b0, 8'h00, 4'h0, 32'h0, {DEV_ID, 16'h0000}};
    rows[1] = '{1'b0, 8'h08, 4'h0, 32'h0, {24'h0, REV_HI, REV_LO}};
    rows[2] = '{1'b0, 8'h04, 4'h0, 32'h0, 32'h0290_0000};
    rows[3] = '{1'b1, 8'h04, 4'hF, '1, 32'h0290_0147};
    rows[4] = '{1'b1, 8'h04, 4'h1, 32'h0, 32'h0290_0100};
    rows[5] = '{1'b1, 8'h04, 4'h2, 32'h0, 32'h0290_0000};
    rows[6] = '{1'b1, 8'h00, 4'hF, '1, {DEV_ID, 16'h0000}};
    rows[7] = '{1'b1, 8'h0C, 4'hF, '1, 32'h0000_0000};
    rows[8] = '{1'b1, 8'h08, 4'hF, '1, {24'h0, REV_HI, REV_LO}};
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        cfg_write(rows[i].addr, rows[i].be, rows[i].wdata);
      end
      cfg_read(rows[i].addr, rows[i].exp);
    end
    // Claims with enables off, then on; decoders hold valid bases
    claim(1'b0, 1'b1, 1'b0, 1'b0);
    claim(1'b1, 1'b0, 1'b0, 1'b0);
    set_cmd(16'h0003);
    check_bit(io_space_enable_o, 1'b1, "io enable");
    check_bit(memory_space_enable_o, 1'b1, "mem enable");
    claim(1'b1, 1'b0, 1'b0, 1'b1);
    claim(1'b0, 1'b1, 1'b0, 1'b1);
    claim(1'b0, 1'b0, 1'b1, 1'b0);
    expansion_rom_enable_i = 1'b1;
    claim(1'b0, 1'b0, 1'b1, 1'b1);
    check_bit(rom_decode_enable_o, 1'b1, "rom decode");
    set_cmd(16'h0001);
    claim(1'b0, 1'b0, 1'b1, 1'b0);
    check_bit(rom_decode_enable_o, 1'b0, "rom decode off");
    cfg_read(8'h04, 32'h0290_0001);
    // Parity errors with the response enable clear, then set
    set_cmd(16'h0100);
    bad_phase(2'd0, 1'b0, 1'b0);
    cfg_write(8'h04, 4'h8, 32'h0000_0000);
    cfg_read(8'h04, 32'h8290_0100);
    clr(16'h0100);
    bad_phase(2'd1, 1'b0, 1'b0);
    cfg_read(8'h04, 32'h8290_0100);
    bad_phase(2'd2, 1'b0, 1'b0);
    cfg_read(8'h04, 32'h8290_0100);
    set_cmd(16'h0140);
    bad_phase(2'd0, 1'b1, 1'b0);
    cfg_read(8'h04, 32'hC290_0140);
    clr(16'h0140);
    bad_phase(2'd1, 1'b0, 1'b1);
    cfg_read(8'h04, 32'h8290_0140);
    bad_phase(2'd2, 1'b0, 1'b1);
    cfg_read(8'h04, 32'h8390_0140);
    clr(16'h0140);
    // Target flags a parity error on our memory write
    @(negedge clk_i);
    mst_wr_xfer_i = 1'b1;
    u_host.target_perr(1'b1);
    @(negedge clk_i);
    mst_wr_xfer_i = 1'b0;
    u_host.target_perr(1'b0);
    cfg_read(8'h04, 32'h8390_0140);
    clr(16'h0140);
    // Back-to-back aborts, then a single-bit clear
    @(negedge clk_i);
    mst_master_abort_i = 1'b1;
    @(negedge clk_i);
    mst_master_abort_i = 1'b0;
    mst_target_abort_i = 1'b1;
    @(negedge clk_i);
    mst_target_abort_i = 1'b0;
    cfg_read(8'h04, 32'h3290_0140);
    cfg_write(8'h04, 4'h8, 32'h2000_0000);
    cfg_read(8'h04, 32'h1290_0140);
    // Event beats its clear in the same cycle
    fork
      cfg_write(8'h04, 4'h8, 32'h2000_0000);
      @(negedge clk_i) mst_master_abort_i = 1'b1;
    join
    mst_master_abort_i = 1'b0;
    cfg_read(8'h04, 32'h3290_0140);
    // Request held off until bus mastering is enabled
    mst_req_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check_bit(bus_req_o, 1'b0, "request gated");
    set_cmd(16'h0144);
    @(negedge clk_i);
    check_bit(bus_req_o, 1'b1, "request passed");
    check_bit(bus_master_enable_o, 1'b1, "bm enable");
    check_bit(parity_response_enable_o, 1'b1, "pre enable");
    check_bit(system_error_enable_o, 1'b1, "see enable");
    // Hardware reset in mid-run wipes command and flags
    @(negedge clk_i);
    nrst_i = 1'b0;
    @(negedge clk_i);
    check_bit(bus_req_o, 1'b0, "request in reset");
    nrst_i = 1'b1;
    cfg_read(8'h04, 32'h0290_0000);
    check_bit(bus_master_enable_o, 1'b0, "bm after reset");
    end_sim();
  end
endmodule
